// file: src/pmcc_pkg.sv
package pmcc_pkg;
  // Special-function register addresses
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;
  localparam logic [7:0] ADDR_EXT_INT_FLAGS = 8'h91;
  localparam logic [7:0] ADDR_POWER_MGMT = 8'hC4;
  localparam logic [7:0] ADDR_CPU_STATUS = 8'hC5;

  // Field positions
  localparam int CLOCK_CONTROL_T2_BIT = 5;
  localparam int CLOCK_CONTROL_T1_BIT = 4;
  localparam int CLOCK_CONTROL_T0_BIT = 3;
  localparam int EXTERNAL_INT_FLAGS_SRC_BIT = 3;
  localparam int EXTERNAL_INT_FLAGS_RING_BIT = 2;
  localparam int PMR_DIV_HI_BIT = 7;
  localparam int PMR_DIV_LO_BIT = 6;
  localparam int PMR_SWB_BIT = 5;
  localparam int PMR_XOFF_BIT = 3;
  localparam int STAT_CRYSTAL_STABLE_FLAG_BIT = 4;

  // Divider codes
  localparam logic [1:0] DIV_CODE_4 = 2'h1;
  localparam logic [1:0] DIV_CODE_64 = 2'h2;
  localparam logic [1:0] DIV_CODE_1024 = 2'h3;

  // Clocks per cycle
  localparam int CLKS_FAST = 4;
  localparam int CLKS_64 = 64;
  localparam int CLKS_1024 = 1024;
  localparam int CLKS_TIMER_SLOW = 12;

  // Reset values
  localparam logic [1:0] DIV_RESET = DIV_CODE_4;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
  localparam logic SRC_RESET = 1'b1;
  localparam logic CRYSTAL_STABLE_FLAG_RESET = 1'b1;

  // Oscillator waits at power-up and at crystal restart, in clocks
  localparam int POR_WAIT_CLKS = 65536;
  localparam int XTAL_RESTART_CLKS = 65536;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmcc_sfr_req_t;

  typedef struct packed {
    logic powerfail_irq_active;
    logic high_irq_active;
    logic low_irq_active;
    logic serial1_tx_active;
    logic serial1_rx_active;
    logic serial0_tx_active;
    logic serial0_rx_active;
  } pmcc_status_in_t;

  typedef enum logic [1:0] {
    PWR_HOLD,
    PWR_WAIT,
    PWR_RUN
  } pmcc_pwr_state_t;
endpackage

// file: src/pmcc_tick_div.sv
`timescale 1ns/10ps
// Programmable enable divider: one pulse every period clocks
module pmcc_tick_div
  import pmcc_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic [CNT_W-1:0] period_m1,
  output logic tick
);
  logic [CNT_W-1:0] count_ff;

  initial
  begin
    if (CNT_W < 2)
      $error("pmcc_tick_div: CNT_W too small");
  end

  // Restart from zero whenever idle so the first tick is a full period
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      count_ff <= '0;
    else if (!run || count_ff >= period_m1)
      count_ff <= '0;
    else
      count_ff <= count_ff + 1'b1;
  end

  assign tick = run && (count_ff >= period_m1);
endmodule

// file: src/pmcc_top.sv
`timescale 1ns/10ps
// Operation
// R1 - Divider code 01 gives 4, 10 gives 64, 11 gives 1024 clocks; 00 reserved
// R2 - New divider selection applies after one further instruction cycle
// R3 - Selected divider slows timers and serial baud too, not only execution
// R4 - Codes 10 or 11 accepted only while divider holds 01
// R5 - Source select 1 means crystal, 0 means ring oscillator
// R6 - Source 0 to 1 only when crystal stable and amplifier on
// R7 - Ring mode flag reads 1 while clocked by ring, resets to 0
// R8 - Auto switchback enable lets hardware return divider to 4 clocks
// R9 - Amplifier off stops crystal; settable only while ring selected; resets 0
// R10 - Crystal stable flag reads 1 once stabilized; resets to 1
// R11 - Ring clock passes through the same 4, 64 or 1024 divider
// R12 - Three bits pick 4 or 12 clocks for timers 2, 1, 0
// R13 - After reset timers run at 12 clocks, instructions at 4; core_reset alone keeps the timer bits as written
// R14 - Hold reset until supply good, then count 65536 clocks, release
// R15 - Supply below threshold asserts and holds reset without software
// R16 - Status register shows irq-in-service and serial activity, all reset 0
// R17 - Software leaves slow mode: select 4 clocks, then reselect crystal
// R18 - Software enters low power: divider, then ring, then amplifier off
// R19 - Single-cycle switchback request rewrites divider to 4 clocks if enabled
// R20 - Stable flag clears on amplifier off, sets after restart count
module pmcc_top
  import pmcc_pkg::*;
#(
  parameter int POR_WAIT = POR_WAIT_CLKS,
  parameter int XTAL_RESTART = XTAL_RESTART_CLKS
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic supply_ok,
  input wire logic ring_clock_pin,
  input wire pmcc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire pmcc_status_in_t status_in,
  input wire logic switchback_req,
  output logic core_reset,
  output logic crystal_amp_en,
  output logic ring_osc_en,
  output logic cpu_on_ring,
  output logic cycle_tick,
  output logic timer0_tick,
  output logic timer1_tick,
  output logic timer2_tick,
  output logic slow_divide_mode,
  output logic divide64_mode,
  output logic divide1024_mode,
  output logic ring_clock_seen
);
  localparam int WAIT_W = $clog2(POR_WAIT + 1);
  localparam int XW = $clog2(XTAL_RESTART + 1);
  initial
  begin
    if (POR_WAIT < 1 || XTAL_RESTART < 1)
      $error("pmcc_top: wait counts must be at least 1");
  end

  // Supply flag and ring pin are asynchronous, so both pass two flops
  // Ring pin is only watched for activity; the core clock mux is analog
  logic sup_meta_ff;
  logic sup_sync_ff;
  logic ring_meta_ff;
  logic ring_sync_ff;
  logic ring_prev_ff;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sup_meta_ff <= 1'b0;
      sup_sync_ff <= 1'b0;
      ring_meta_ff <= 1'b0;
      ring_sync_ff <= 1'b0;
      ring_prev_ff <= 1'b0;
    end
    else
    begin
      sup_meta_ff <= supply_ok;
      sup_sync_ff <= sup_meta_ff;
      ring_meta_ff <= ring_clock_pin;
      ring_sync_ff <= ring_meta_ff;
      ring_prev_ff <= ring_sync_ff;
    end
  end
  assign ring_clock_seen = ring_sync_ff ^ ring_prev_ff;

  // Power-on sequencer
  pmcc_pwr_state_t pwr_state_ff;
  logic [WAIT_W-1:0] por_count_ff;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pwr_state_ff <= PWR_HOLD;
      por_count_ff <= '0;
    end
    // R15 brown-out hold
    else if (!sup_sync_ff)
    begin
      pwr_state_ff <= PWR_HOLD;
      por_count_ff <= '0;
    end
    else
    begin
      case (pwr_state_ff)
        PWR_HOLD:
        begin
          pwr_state_ff <= PWR_WAIT;
          por_count_ff <= '0;
        end
        // R14 oscillator wait count
        PWR_WAIT:
        begin
          if (por_count_ff == WAIT_W'(POR_WAIT - 1))
            pwr_state_ff <= PWR_RUN;
          else
            por_count_ff <= por_count_ff + 1'b1;
        end
        PWR_RUN:
          pwr_state_ff <= PWR_RUN;
        default:
          pwr_state_ff <= PWR_HOLD;
      endcase
    end
  end
  logic in_reset;
  assign in_reset = (pwr_state_ff != PWR_RUN);
  assign core_reset = in_reset;
  // Register decode
  logic wr_ck, wr_ex, wr_pm;
  assign wr_ck = sfr_req.wr && !in_reset && (sfr_req.addr == ADDR_CLOCK_CONTROL);
  assign wr_ex = sfr_req.wr && !in_reset && (sfr_req.addr == ADDR_EXT_INT_FLAGS);
  assign wr_pm = sfr_req.wr && !in_reset && (sfr_req.addr == ADDR_POWER_MGMT);
  logic [1:0] div_sel_ff;
  logic [1:0] div_act_ff;
  logic div_pend_ff;
  logic auto_switchback_en_ff;
  logic crystal_amp_off_ff;
  logic clock_source_sel_ff;
  logic crystal_stable_flag_ff;
  logic [2:0] timer_fast_ff;
  logic [7:0] clock_control_other_ff;
  logic [XW-1:0] xtal_count_ff;
  logic [1:0] wdiv;
  assign wdiv = sfr_req.wdata[PMR_DIV_HI_BIT:PMR_DIV_LO_BIT];
  // Divider select register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      div_sel_ff <= DIV_RESET;
    else if (in_reset)
      div_sel_ff <= DIV_RESET;
    // R19 hardware switchback request
    else if (switchback_req && auto_switchback_en_ff)
      div_sel_ff <= DIV_CODE_4;
    else if (wr_pm)
    begin
      // R4 slow codes only from 4-clock code
      if (wdiv == DIV_CODE_4)
        div_sel_ff <= wdiv;
      else if (wdiv != 2'h0 && div_sel_ff == DIV_CODE_4)
        div_sel_ff <= wdiv;
    end
  end

  function automatic logic [9:0] period_of(input logic [1:0] code);
    // R1 code to clocks per cycle
    case (code)
      DIV_CODE_64: period_of = 10'(CLKS_64 - 1);
      DIV_CODE_1024: period_of = 10'(CLKS_1024 - 1);
      default: period_of = 10'(CLKS_FAST - 1);
    endcase
  endfunction

  // R2 apply on second cycle boundary after write
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      div_act_ff <= DIV_RESET;
      div_pend_ff <= 1'b0;
    end
    else if (in_reset)
    begin
      div_act_ff <= DIV_RESET;
      div_pend_ff <= 1'b0;
    end
    else if (div_sel_ff != div_act_ff)
    begin
      if (cycle_tick && div_pend_ff)
      begin
        div_act_ff <= div_sel_ff;
        div_pend_ff <= 1'b0;
      end
      else if (cycle_tick)
        div_pend_ff <= 1'b1;
    end
    else
      div_pend_ff <= 1'b0;
  end

  // R11 same divider for ring or crystal source
  pmcc_tick_div #(
    .CNT_W(10)
  ) u_cycle_div (
    .clock(clock),
    .reset(reset),
    .run(!in_reset),
    .period_m1(period_of(div_act_ff)),
    .tick(cycle_tick)
  );

  assign slow_divide_mode = (div_act_ff != DIV_CODE_4);
  assign divide64_mode = (div_act_ff == DIV_CODE_64);
  assign divide1024_mode = (div_act_ff == DIV_CODE_1024);

  // Timer prescale: every third cycle tick gives the 12-clock rate
  logic [1:0] third_ff;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      third_ff <= '0;
    else if (in_reset)
      third_ff <= '0;
    else if (cycle_tick)
      third_ff <= (third_ff == 2'h2) ? 2'h0 : third_ff + 2'h1;
  end
  logic slow_tick;
  assign slow_tick = cycle_tick && (third_ff == 2'h2);

  // R3 timers derive from the cycle tick
  // R12 per-timer 4 or 12 clocks
  // R13 reset value selects 12 clocks
  assign timer0_tick = timer_fast_ff[0] ? cycle_tick : slow_tick;
  assign timer1_tick = timer_fast_ff[1] ? cycle_tick : slow_tick;
  assign timer2_tick = timer_fast_ff[2] ? cycle_tick : slow_tick;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      timer_fast_ff <= CLOCK_CONTROL_RESET[CLOCK_CONTROL_T2_BIT:CLOCK_CONTROL_T0_BIT];
      clock_control_other_ff <= CLOCK_CONTROL_RESET;
    end
    else if (wr_ck)
    begin
      timer_fast_ff <= sfr_req.wdata[CLOCK_CONTROL_T2_BIT:CLOCK_CONTROL_T0_BIT];
      clock_control_other_ff <= sfr_req.wdata & 8'hC7;
    end
  end

  // R8 freely writable enable
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      auto_switchback_en_ff <= 1'b0;
    else if (in_reset)
      auto_switchback_en_ff <= 1'b0;
    else if (wr_pm)
      auto_switchback_en_ff <= sfr_req.wdata[PMR_SWB_BIT];
  end

  // R9 amplifier off settable only on ring
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      crystal_amp_off_ff <= 1'b0;
    else if (in_reset)
      crystal_amp_off_ff <= 1'b0;
    else if (wr_pm)
    begin
      if (!sfr_req.wdata[PMR_XOFF_BIT])
        crystal_amp_off_ff <= 1'b0;
      else if (!clock_source_sel_ff)
        crystal_amp_off_ff <= 1'b1;
    end
  end
  assign crystal_amp_en = !crystal_amp_off_ff;
  assign ring_osc_en = !clock_source_sel_ff;

  // R5 source select
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      clock_source_sel_ff <= SRC_RESET;
    else if (in_reset)
      clock_source_sel_ff <= SRC_RESET;
    else if (wr_ex)
    begin
      if (!sfr_req.wdata[EXTERNAL_INT_FLAGS_SRC_BIT])
        clock_source_sel_ff <= 1'b0;
      // R6 return to crystal only when stable
      else if (crystal_stable_flag_ff && !crystal_amp_off_ff)
        clock_source_sel_ff <= 1'b1;
    end
  end
  // R7 ring mode follows the source in use
  assign cpu_on_ring = !clock_source_sel_ff;

  // R20 stable flag tracks amplifier restart
  // R10 reads 1 after reset
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      crystal_stable_flag_ff <= CRYSTAL_STABLE_FLAG_RESET;
      xtal_count_ff <= '0;
    end
    else if (in_reset)
    begin
      crystal_stable_flag_ff <= CRYSTAL_STABLE_FLAG_RESET;
      xtal_count_ff <= '0;
    end
    else if (crystal_amp_off_ff)
    begin
      crystal_stable_flag_ff <= 1'b0;
      xtal_count_ff <= '0;
    end
    else if (!crystal_stable_flag_ff)
    begin
      if (xtal_count_ff == XW'(XTAL_RESTART - 1))
        crystal_stable_flag_ff <= 1'b1;
      else
        xtal_count_ff <= xtal_count_ff + 1'b1;
    end
  end

  // Read mux, registered; unmapped addresses read zero
  logic [7:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 8'h00;
    case (sfr_req.addr)
      ADDR_CLOCK_CONTROL:
      begin
        nxt_rdata = clock_control_other_ff;
        nxt_rdata[CLOCK_CONTROL_T2_BIT:CLOCK_CONTROL_T0_BIT] = timer_fast_ff;
      end
      ADDR_EXT_INT_FLAGS:
      begin
        nxt_rdata[EXTERNAL_INT_FLAGS_SRC_BIT] = clock_source_sel_ff;
        nxt_rdata[EXTERNAL_INT_FLAGS_RING_BIT] = !clock_source_sel_ff;
      end
      ADDR_POWER_MGMT:
      begin
        nxt_rdata[PMR_DIV_HI_BIT:PMR_DIV_LO_BIT] = div_sel_ff;
        nxt_rdata[PMR_SWB_BIT] = auto_switchback_en_ff;
        nxt_rdata[PMR_XOFF_BIT] = crystal_amp_off_ff;
      end
      // R16 status flags, forced 0 in reset except crystal stable bit, which reads 1
      ADDR_CPU_STATUS:
      begin
        nxt_rdata = {status_in[6:4], crystal_stable_flag_ff, status_in[3:0]};
        if (in_reset)
          nxt_rdata = 8'h00 | (8'(CRYSTAL_STABLE_FLAG_RESET) << STAT_CRYSTAL_STABLE_FLAG_BIT);
      end
      default:
        nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd)
      sfr_rdata <= nxt_rdata;
  end
endmodule

// file: tb/pmcc_checker.sv
`timescale 1ns/10ps
module pmcc_checker
  import pmcc_pkg::*;
#(
  parameter int POR_WAIT = 16
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic supply_ok,
  input wire logic core_reset,
  input wire logic crystal_amp_en,
  input wire logic ring_osc_en,
  input wire logic cycle_tick,
  input wire logic timer0_tick,
  input wire logic slow_divide_mode,
  input wire logic divide64_mode,
  input wire logic divide1024_mode
);
  logic [10:0] gap_ff;
  logic [1:0] last_ff;
  logic [19:0] ok_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Code 3 marks no tick seen yet, so the first gap is never judged
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      gap_ff <= 11'h000;
      last_ff <= 2'h3;
    end
    else if (core_reset)
    begin
      gap_ff <= 11'h000;
      last_ff <= 2'h3;
    end
    else if (cycle_tick)
    begin
      gap_ff <= 11'h001;
      last_ff <= {divide1024_mode, divide64_mode};
    end
    else
      gap_ff <= gap_ff + 11'h001;
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      ok_ff <= 20'h00000;
    else if (!supply_ok)
      ok_ff <= 20'h00000;
    else
      ok_ff <= ok_ff + 20'h00001;
  end
  chk_fast_gap: assert property (
    cycle_tick && !slow_divide_mode && last_ff == 2'h0 |-> gap_ff == 11'h004)
    else $error("fast cycle gap wrong");
  chk_div64_gap: assert property (
    cycle_tick && divide64_mode && last_ff == 2'h1 |-> gap_ff == 11'h040)
    else $error("divide 64 gap wrong");
  chk_div1024_gap: assert property (
    cycle_tick && divide1024_mode && last_ff == 2'h2 |-> gap_ff == 11'h400)
    else $error("divide 1024 gap wrong");
  chk_mode_code: assert property (
    slow_divide_mode == (divide64_mode ^ divide1024_mode))
    else $error("mode flags inconsistent");
  chk_amp_ring: assert property (
    !crystal_amp_en |-> ring_osc_en)
    else $error("amplifier off while on crystal");
  chk_timer_sub: assert property (
    timer0_tick |-> cycle_tick)
    else $error("timer tick outside cycle tick");
  chk_supply_drop: assert property (
    !supply_ok [*3] |-> ##[0:2] core_reset)
    else $error("no reset on supply loss");
  chk_por_wait: assert property (
    $fell(core_reset) |-> ok_ff >= POR_WAIT && ok_ff <= POR_WAIT + 4)
    else $error("reset released early or late");
  chk_hold_tick: assert property (
    core_reset |-> !cycle_tick)
    else $error("cycle tick during reset");
  chk_switch_on_tick: assert property (
    $changed(slow_divide_mode) && !core_reset |-> $past(cycle_tick))
    else $error("divider mode changed off a cycle boundary");
  cover property (divide64_mode && cycle_tick);
  cover property (divide1024_mode && cycle_tick);
  cover property ($fell(core_reset));
endmodule

// file: tb/power_mgmt_clock_control_tb.sv
`timescale 1ns/10ps
module power_mgmt_clock_control_tb
  import pmcc_pkg::*;
;
  localparam int PW = 16;
  localparam int XR = 16;
  logic clock;
  logic reset = 1'b1;
  logic supply_ok = 1'b0;
  logic ring_clock_pin = 1'b0;
  logic switchback_req = 1'b0;
  pmcc_sfr_req_t sfr_req = '0;
  pmcc_status_in_t status_in = '0;
  logic [7:0] sfr_rdata, ck_v;
  logic [6:0] st_v = 7'h00;
  logic core_reset, crystal_amp_en, ring_osc_en, cpu_on_ring, cycle_tick;
  logic t0, t1, t2, slow_divide_mode, divide64_mode, divide1024_mode;
  int mismatches = 0;
  int n_checks = 0;
  logic ring_seen;
  int nc, n0, n1, n2, nr;
  pmcc_top #(.POR_WAIT(PW), .XTAL_RESTART(XR)) dut_u (.clock(clock), .reset(reset),
    .supply_ok(supply_ok), .ring_clock_pin(ring_clock_pin), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .status_in(status_in), .switchback_req(switchback_req),
    .core_reset(core_reset), .crystal_amp_en(crystal_amp_en), .ring_osc_en(ring_osc_en),
    .cpu_on_ring(cpu_on_ring), .cycle_tick(cycle_tick), .timer0_tick(t0),
    .timer1_tick(t1), .timer2_tick(t2), .slow_divide_mode(slow_divide_mode),
    .divide64_mode(divide64_mode), .divide1024_mode(divide1024_mode),
    .ring_clock_seen(ring_seen));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) ring_clock_pin <= ~ring_clock_pin;
  function automatic logic [7:0] stx(input logic x);
    return {st_v[6:4], x, st_v[3:0]};
  endfunction
  function automatic logic [7:0] tk(input logic fast);
    return fast ? 8'h1E : 8'h0A;
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    sfr_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    sfr_req <= '0;
    #1;
    chk8(sfr_rdata, exp);
  endtask
  task automatic pulse_swb;
    @(posedge clock);
    switchback_req <= 1'b1;
    @(posedge clock);
    switchback_req <= 1'b0;
  endtask
  task automatic count(input int n);
    nc = 0;
    n0 = 0;
    n1 = 0;
    n2 = 0;
    nr = 0;
    repeat (n)
    begin
      @(posedge clock);
      #1;
      nc += cycle_tick;
      nr += ring_seen;
      n0 += t0;
      n1 += t1;
      n2 += t2;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #(40 * 30000);
    mismatches++;
    report_and_stop;
  end
  initial
  begin
    void'($urandom(3));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (10) @(posedge clock);
    chk8({7'h00, core_reset}, 8'h01);
    supply_ok <= 1'b1;
    repeat (PW + 8) @(posedge clock);
    chk8({7'h00, core_reset}, 8'h00);
    rd(ADDR_POWER_MGMT, 8'h40);
    rd(ADDR_EXT_INT_FLAGS, 8'h08);
    rd(ADDR_CLOCK_CONTROL, 8'h00);
    rd(ADDR_CPU_STATUS, 8'h10);
    count(120);
    chk8(8'(nc + n0 + n1 + n2), 8'h3C);
    for (int i = 0; i < 3; i++)
    begin
      ck_v = (i == 0) ? 8'h38 : 8'($urandom);
      st_v = 7'($urandom);
      status_in <= st_v;
      wr(ADDR_CLOCK_CONTROL, ck_v);
      rd(ADDR_CLOCK_CONTROL, ck_v);
      rd(ADDR_CPU_STATUS, stx(1'b1));
      count(120);
      chk8({8'(n2), 8'(n1), 8'(n0)} == {tk(ck_v[5]), tk(ck_v[4]), tk(ck_v[3])}, 1);
    end
    wr(ADDR_CLOCK_CONTROL, 8'h38);
    wr(ADDR_POWER_MGMT, 8'h00);
    rd(ADDR_POWER_MGMT, 8'h40);
    wr(ADDR_POWER_MGMT, 8'h80);
    rd(ADDR_POWER_MGMT, 8'h80);
    chk8({7'h00, slow_divide_mode}, 8'h00);
    repeat (140) @(posedge clock);
    count(640);
    chk8({8'(nc), 8'(n0)} == 16'h0A0A, 1);
    chk8({5'h00, slow_divide_mode, divide64_mode, divide1024_mode}, 8'h06);
    wr(ADDR_POWER_MGMT, 8'hC0);
    rd(ADDR_POWER_MGMT, 8'h80);
    wr(ADDR_POWER_MGMT, 8'hA0);
    pulse_swb;
    rd(ADDR_POWER_MGMT, 8'h60);
    repeat (140) @(posedge clock);
    chk8({7'h00, slow_divide_mode}, 8'h00);
    wr(ADDR_POWER_MGMT, 8'h80);
    pulse_swb;
    rd(ADDR_POWER_MGMT, 8'h80);
    wr(ADDR_POWER_MGMT, 8'h40);
    repeat (140) @(posedge clock);
    wr(ADDR_POWER_MGMT, 8'hC0);
    repeat (2100) @(posedge clock);
    count(3072);
    chk8(8'(nc), 8'h03);
    chk8({7'h00, divide1024_mode}, 8'h01);
    wr(ADDR_POWER_MGMT, 8'h80);
    rd(ADDR_POWER_MGMT, 8'hC0);
    wr(ADDR_POWER_MGMT, 8'h40);
    repeat (2100) @(posedge clock);
    chk8({7'h00, slow_divide_mode}, 8'h00);
    wr(ADDR_POWER_MGMT, 8'h48);
    rd(ADDR_POWER_MGMT, 8'h40);
    wr(ADDR_EXT_INT_FLAGS, 8'h00);
    repeat (10) @(posedge clock);
    rd(ADDR_EXT_INT_FLAGS, 8'h04);
    chk8({6'h00, ring_osc_en, cpu_on_ring}, 8'h03);
    count(120);
    chk8(8'(nc), 8'h1E);
    chk8(8'(nr), 8'h78);
    wr(ADDR_POWER_MGMT, 8'h48);
    rd(ADDR_POWER_MGMT, 8'h48);
    rd(ADDR_CPU_STATUS, stx(1'b0));
    wr(ADDR_EXT_INT_FLAGS, 8'h08);
    repeat (10) @(posedge clock);
    rd(ADDR_EXT_INT_FLAGS, 8'h04);
    wr(ADDR_POWER_MGMT, 8'h40);
    repeat (XR + 10) @(posedge clock);
    rd(ADDR_CPU_STATUS, stx(1'b1));
    wr(ADDR_EXT_INT_FLAGS, 8'h08);
    repeat (10) @(posedge clock);
    rd(ADDR_EXT_INT_FLAGS, 8'h08);
    supply_ok <= 1'b0;
    repeat (6) @(posedge clock);
    chk8({7'h00, core_reset}, 8'h01);
    supply_ok <= 1'b1;
    repeat (PW + 8) @(posedge clock);
    chk8({7'h00, core_reset}, 8'h00);
    report_and_stop;
  end
endmodule
bind pmcc_top pmcc_checker #(.POR_WAIT(POR_WAIT)) chk_u (.clock(clock), .reset(reset),
  .supply_ok(supply_ok), .core_reset(core_reset), .crystal_amp_en(crystal_amp_en),
  .ring_osc_en(ring_osc_en), .cycle_tick(cycle_tick), .timer0_tick(timer0_tick),
  .slow_divide_mode(slow_divide_mode), .divide64_mode(divide64_mode),
  .divide1024_mode(divide1024_mode));
